// File: inc/preamp_params_params.svh
// Constants for the preamplifier serial control port.
// Assumes a 40 MHz system clock and a 16-bit control word.
`ifndef PREAMP_PARAMS_PARAMS_SVH
`define PREAMP_PARAMS_PARAMS_SVH

// ==========================================================
// Control word layout
`define WORD_BITS        16
`define WORD_RESET       16'h0000
`define GAIN_LSB         0
`define GAIN_BITS        6
`define SERVO_OFF_POS    7
`define CM_SERVO_POS     8
`define THRESH_SEL_POS   9
`define AUX_LSB          12
`define AUX_BITS         4

// ==========================================================
// Gain coding: code 0 is unity, codes 1..56 are 10..65 dB
`define GAIN_UNITY_CODE  6'h00
`define GAIN_MAX_CODE    6'h38
`define GAIN_DB_OFFSET   7'h09
`define GAIN_UNITY_DB    7'h00
`define GAIN_MIN_DB      7'h0a
`define GAIN_MAX_DB      7'h41
`define GAIN_DB_BITS     7

// ==========================================================
// Timing
`define SYS_CLK_HZ       40000000
`define ZC_TIMEOUT_MS    16
`define ZC_TIMEOUT_CYC   (`ZC_TIMEOUT_MS * (`SYS_CLK_HZ / 1000))
`define ZC_TIMER_BITS    20

// ==========================================================
// Synchroniser vector bit positions
`define SYNC_BITS        7
`define SYNC_CS_HIGH     0
`define SYNC_SERVO_PIN   1
`define SYNC_FORCE       2
`define SYNC_ZC_EN       3
`define SYNC_SIGN        4
`define SYNC_OVER_HIGH   5
`define SYNC_OVER_LOW    6
`define SYNC_RESET       7'h01

`endif

// File: inc/preamp_pkg.sv
// Types shared by the serial control port modules.
// Assumes the constants header is on the include path.
`include "preamp_params_params.svh"

package preamp_pkg;

    // ==========================================================
    // Gain change sequencer
    typedef enum logic [1:0] {
        ZC_IDLE = 2'h0,
        ZC_WAIT = 2'h1
    } zc_state_e;

    // ==========================================================
    // System domain state
    typedef struct packed {
        logic                         cs_high_prev;
        logic [`WORD_BITS-1:0]        word;
        logic [`GAIN_BITS-1:0]        applied_code;
        logic [`GAIN_DB_BITS-1:0]     gain_db;
        logic                         sign_prev;
        logic [`ZC_TIMER_BITS-1:0]    timer;
        zc_state_e                    state;
        logic                         dc_servo_en;
        logic                         cm_servo_en;
        logic                         clip;
        logic [`AUX_BITS-1:0]         aux;
    } ctrl_s;

    // ==========================================================
    // Link domain state
    typedef struct packed {
        logic [`WORD_BITS-1:0]        shift;
    } link_shift_s;

    typedef struct packed {
        logic                         out_bit;
    } link_out_s;

endpackage : preamp_pkg

// File: core/preamp_sync2.sv
// Two-stage synchroniser for a vector of independent levels.
// Assumes each bit is a slow level; no bus coherence is offered.
`timescale 1ns/100ps

module preamp_sync2 #(
    parameter int                 WIDTH     = 1,
    parameter logic [WIDTH-1:0]   RESET_VAL = '0
) (
    input  wire logic             clk_sys_in,
    input  wire logic             rst_n_in,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);

    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] held;
    } sync_s;

    sync_s sync_reg;
    sync_s sync_next;

    generate
        if (WIDTH < 1) begin : g_bad_width
            $error("preamp_sync2 needs WIDTH of at least 1");
        end
    endgenerate

    // ==========================================================
    // Stages
    always_comb begin
        sync_next.meta = async_in;
        sync_next.held = sync_reg.meta;
    end

    always_ff @(posedge clk_sys_in) begin
        if (!rst_n_in) begin
            sync_reg <= {RESET_VAL, RESET_VAL};
        end else begin
            sync_reg <= sync_next;
        end
    end

    assign sync_out = sync_reg.held;

endmodule : preamp_sync2

// File: core/preamp_link_shifter.sv
// Serial shift register clocked by the host's serial clock.
// Assumes the serial clock only runs while chip select is low.
`timescale 1ns/100ps
`include "preamp_params_params.svh"

module preamp_link_shifter (
    input  wire logic                  serial_clk_in,
    input  wire logic                  cs_n_in,
    input  wire logic                  serial_in,
    output logic [`WORD_BITS-1:0]      shift_word_out,
    output logic                       serial_out_out,
    output logic                       serial_out_oe_out
);

    preamp_pkg::link_shift_s shift_reg;
    preamp_pkg::link_shift_s shift_next;
    preamp_pkg::link_out_s   out_reg;
    preamp_pkg::link_out_s   out_next;

    // ==========================================================
    // Shift in on rising edges, MSB first
    always_comb begin
        shift_next = shift_reg;
        if (!cs_n_in) begin                                        // R1 R4
            shift_next.shift = {shift_reg.shift[`WORD_BITS-2:0], serial_in}; // R6 R21
        end
    end

    always_ff @(posedge serial_clk_in) begin
        shift_reg <= shift_next;
    end

    // ==========================================================
    // Drive out on falling edges; no reset since the clock is gated
    always_comb begin
        out_next = out_reg;
        if (!cs_n_in) begin
            out_next.out_bit = shift_reg.shift[`WORD_BITS-1];      // R7 R8
        end
    end

    always_ff @(negedge serial_clk_in) begin
        out_reg <= out_next;
    end

    assign shift_word_out    = shift_reg.shift;
    assign serial_out_out    = out_reg.out_bit;
    assign serial_out_oe_out = ~cs_n_in;                           // R5

    // ==========================================================
    // Checks
    a_shift_entry: assert property (@(posedge serial_clk_in) disable iff (cs_n_in) // R6
        1'b1 |=> shift_reg.shift[0] == $past(serial_in))
        else $error("serial input bit not taken");

    // Unreset register carries unknown bits through its first frame
    a_out_msb: assert property (@(negedge serial_clk_in) disable iff (cs_n_in) // R7 R8
        1'b1 |=> out_reg.out_bit === $past(shift_reg.shift[`WORD_BITS-1]))
        else $error("serial output not shift register end");

endmodule : preamp_link_shifter

// File: core/preamp_serial_control_port.sv
// Serial control port of a programmed microphone preamplifier.
// Assumes the analog side supplies input sign and overload comparators.
//
// Notes on behaviour
// R1: Chip select low frames every transfer.
// R2: One 16-bit word sets all functions.
// R3: Word latched on chip select rising.
// R4: Clock and data ignored while deselected.
// R5: Serial output released while deselected.
// R6: Serial input sampled on rising clock.
// R7: Serial output changes on falling clock.
// R8: Serial output is shift register end.
// R9: Gain unity or 10 to 65 dB.
// R10: DC servo off by pin or bit.
// R11: Word bit switches common-mode servo.
// R12: Force pin imposes unity gain.
// R13: Shifting works while forced; gain deferred.
// R14: Zero-cross enable defers gain changes.
// R15: Pending change applied within 16 ms.
// R16: Without zero-cross, gain applies immediately.
// R17: Clip flag high above threshold.
// R18: Select bit picks high or low threshold.
// R19: Four aux outputs follow word bits.
// R20: Host sends 16 times N bits.
// R21: Word shifted most significant bit first.
// R22: Last 16 bits latch, even partial.
`timescale 1ns/100ps
`include "preamp_params_params.svh"

module preamp_serial_control_port #(
    parameter int unsigned ZC_TIMEOUT_CYCLES = `ZC_TIMEOUT_CYC
) (
    input  wire logic                       clk_sys_in,
    input  wire logic                       rst_n_in,
    input  wire logic                       serial_clk_in,
    input  wire logic                       cs_n_in,
    input  wire logic                       serial_in,
    output logic                            serial_out_out,
    output logic                            serial_out_oe_out,
    input  wire logic                       servo_disable_pin_in,
    input  wire logic                       unity_gain_force_in,
    input  wire logic                       zero_cross_enable_in,
    input  wire logic                       input_sign_in,
    input  wire logic                       over_high_in,
    input  wire logic                       over_low_in,
    output logic [`GAIN_BITS-1:0]           gain_code_out,
    output logic [`GAIN_DB_BITS-1:0]        gain_db_out,
    output logic                            unity_gain_active_out,
    output logic                            zc_pending_out,
    output logic                            dc_servo_enable_out,
    output logic                            cm_servo_enable_out,
    output logic                            clip_flag_out,
    output logic                            aux_output_1_out,
    output logic                            aux_output_2_out,
    output logic                            aux_output_3_out,
    output logic                            aux_output_4_out
);

    // ==========================================================
    // Elaboration checks
    generate
        if (ZC_TIMEOUT_CYCLES < 1 || ZC_TIMEOUT_CYCLES >= (1 << `ZC_TIMER_BITS)) begin : g_bad
            $error("ZC_TIMEOUT_CYCLES does not fit the timeout counter");
        end
    endgenerate

    localparam logic [`ZC_TIMER_BITS-1:0] TIMER_LAST =
        `ZC_TIMER_BITS'(ZC_TIMEOUT_CYCLES - 1);

    localparam preamp_pkg::ctrl_s CTRL_RESET = '{
        cs_high_prev: 1'b1,
        word:         `WORD_RESET,
        applied_code: `GAIN_UNITY_CODE,
        gain_db:      `GAIN_UNITY_DB,
        sign_prev:    1'b0,
        timer:        '0,
        state:        preamp_pkg::ZC_IDLE,
        dc_servo_en:  1'b1,
        cm_servo_en:  1'b0,
        clip:         1'b0,
        aux:          '0
    };

    // ==========================================================
    // Gain code to decibels; codes above the top step clamp
    function automatic logic [`GAIN_DB_BITS-1:0] code_to_db(
        input logic [`GAIN_BITS-1:0] code
    );
        logic [`GAIN_DB_BITS-1:0] db;
        db = `GAIN_UNITY_DB;
        if (code == `GAIN_UNITY_CODE) begin
            db = `GAIN_UNITY_DB;
        end else if (code > `GAIN_MAX_CODE) begin
            db = `GAIN_MAX_DB;
        end else begin
            db = `GAIN_DB_BITS'({1'b0, code} + `GAIN_DB_OFFSET);
        end
        return db;
    endfunction : code_to_db

    // ==========================================================
    // Link domain
    logic [`WORD_BITS-1:0] shift_word;

    preamp_link_shifter u_link (
        .serial_clk_in     (serial_clk_in),
        .cs_n_in           (cs_n_in),
        .serial_in         (serial_in),
        .shift_word_out    (shift_word),
        .serial_out_out    (serial_out_out),
        .serial_out_oe_out (serial_out_oe_out)
    );

    // ==========================================================
    // Pin synchronisers
    logic [`SYNC_BITS-1:0] pin_raw;
    logic [`SYNC_BITS-1:0] pin_s;

    assign pin_raw[`SYNC_CS_HIGH]   = cs_n_in;
    assign pin_raw[`SYNC_SERVO_PIN] = servo_disable_pin_in;
    assign pin_raw[`SYNC_FORCE]     = unity_gain_force_in;
    assign pin_raw[`SYNC_ZC_EN]     = zero_cross_enable_in;
    assign pin_raw[`SYNC_SIGN]      = input_sign_in;
    assign pin_raw[`SYNC_OVER_HIGH] = over_high_in;
    assign pin_raw[`SYNC_OVER_LOW]  = over_low_in;

    preamp_sync2 #(
        .WIDTH     (`SYNC_BITS),
        .RESET_VAL (`SYNC_RESET)
    ) u_sync (
        .clk_sys_in (clk_sys_in),
        .rst_n_in   (rst_n_in),
        .async_in   (pin_raw),
        .sync_out   (pin_s)
    );

    // ==========================================================
    // Control state
    preamp_pkg::ctrl_s ctrl_reg;
    preamp_pkg::ctrl_s ctrl_next;

    logic                   cs_rise;
    logic                   force_unity;
    logic                   zc_enabled;
    logic                   crossing;
    logic                   timer_done;
    logic [`GAIN_BITS-1:0]  target_code;
    logic [`WORD_BITS-1:0]  word_now;

    // The shift word is quiet once chip select is high, so sampling it
    // after the synchronised rising edge is a safe crossing.
    assign cs_rise     = pin_s[`SYNC_CS_HIGH] & ~ctrl_reg.cs_high_prev;   // R3
    assign force_unity = pin_s[`SYNC_FORCE];
    assign zc_enabled  = pin_s[`SYNC_ZC_EN];
    assign crossing    = pin_s[`SYNC_SIGN] ^ ctrl_reg.sign_prev;
    assign timer_done  = ctrl_reg.timer >= TIMER_LAST;
    assign word_now    = ctrl_reg.word;
    assign target_code = word_now[`GAIN_LSB +: `GAIN_BITS];               // R2

    always_comb begin
        ctrl_next              = ctrl_reg;
        ctrl_next.cs_high_prev = pin_s[`SYNC_CS_HIGH];
        ctrl_next.sign_prev    = pin_s[`SYNC_SIGN];

        if (cs_rise) begin
            ctrl_next.word = shift_word;                                  // R3 R22
        end

        // Gain sequencing
        if (force_unity) begin
            ctrl_next.applied_code = `GAIN_UNITY_CODE;                    // R12 R13
            ctrl_next.state        = preamp_pkg::ZC_IDLE;
            ctrl_next.timer        = '0;
        end else if (ctrl_reg.applied_code == target_code) begin
            ctrl_next.state = preamp_pkg::ZC_IDLE;
            ctrl_next.timer = '0;
        end else if (!zc_enabled) begin
            ctrl_next.applied_code = target_code;                         // R16
            ctrl_next.state        = preamp_pkg::ZC_IDLE;
            ctrl_next.timer        = '0;
        end else begin
            case (ctrl_reg.state)
                preamp_pkg::ZC_IDLE: begin
                    ctrl_next.state = preamp_pkg::ZC_WAIT;                // R14
                    ctrl_next.timer = '0;
                end
                preamp_pkg::ZC_WAIT: begin
                    if (crossing || timer_done) begin
                        ctrl_next.applied_code = target_code;             // R14 R15
                        ctrl_next.state        = preamp_pkg::ZC_IDLE;
                        ctrl_next.timer        = '0;
                    end else begin
                        ctrl_next.timer = ctrl_reg.timer + 1'b1;
                    end
                end
                default: begin
                    ctrl_next.state = preamp_pkg::ZC_IDLE;
                    ctrl_next.timer = '0;
                end
            endcase
        end
        ctrl_next.gain_db = code_to_db(ctrl_next.applied_code);           // R9

        // Support functions follow the latched word
        ctrl_next.dc_servo_en = ~(pin_s[`SYNC_SERVO_PIN] | word_now[`SERVO_OFF_POS]); // R10
        ctrl_next.cm_servo_en = word_now[`CM_SERVO_POS];                  // R11
        ctrl_next.clip        = word_now[`THRESH_SEL_POS] ?               // R18
                                pin_s[`SYNC_OVER_LOW] : pin_s[`SYNC_OVER_HIGH]; // R17
        ctrl_next.aux         = word_now[`AUX_LSB +: `AUX_BITS];          // R19
    end

    always_ff @(posedge clk_sys_in) begin
        if (!rst_n_in) begin
            ctrl_reg <= CTRL_RESET;
        end else begin
            ctrl_reg <= ctrl_next;
        end
    end

    // ==========================================================
    // Outputs
    assign gain_code_out         = ctrl_reg.applied_code;
    assign gain_db_out           = ctrl_reg.gain_db;
    assign unity_gain_active_out = ctrl_reg.applied_code == `GAIN_UNITY_CODE;
    assign zc_pending_out        = ctrl_reg.state == preamp_pkg::ZC_WAIT;
    assign dc_servo_enable_out   = ctrl_reg.dc_servo_en;
    assign cm_servo_enable_out   = ctrl_reg.cm_servo_en;
    assign clip_flag_out         = ctrl_reg.clip;
    assign aux_output_1_out      = ctrl_reg.aux[0];
    assign aux_output_2_out      = ctrl_reg.aux[1];
    assign aux_output_3_out      = ctrl_reg.aux[2];
    assign aux_output_4_out      = ctrl_reg.aux[3];

    // ==========================================================
    // Checks
    default clocking cb_sys @(posedge clk_sys_in);
    endclocking

    default disable iff (!rst_n_in);

    a_word_latch: assert property (                                     // R3
        cs_rise |=> ctrl_reg.word == $past(shift_word))
        else $error("word not latched on chip select rise");

    a_word_hold: assert property (                                      // R4
        !cs_rise |=> $stable(ctrl_reg.word))
        else $error("word changed without chip select rise");

    a_gain_range: assert property (                                     // R9
        gain_db_out == `GAIN_UNITY_DB ||
        (gain_db_out >= `GAIN_MIN_DB && gain_db_out <= `GAIN_MAX_DB))
        else $error("gain outside its legal range");

    a_force_unity: assert property (                                    // R12
        force_unity |=> gain_code_out == `GAIN_UNITY_CODE && !zc_pending_out)
        else $error("force pin did not impose unity gain");

    a_force_release: assert property (                                  // R13
        $fell(force_unity) && !zc_enabled |=> gain_code_out == $past(target_code))
        else $error("held gain not applied on force release");

    a_direct_apply: assert property (                                   // R16
        !force_unity && !zc_enabled |=> gain_code_out == $past(target_code))
        else $error("gain not applied at once without zero cross");

    a_zc_defer: assert property (                                       // R14
        !force_unity && zc_enabled && !zc_pending_out &&
        gain_code_out != target_code |=> $stable(gain_code_out) && zc_pending_out)
        else $error("gain change not deferred");

    a_zc_bound: assert property (                                       // R15
        zc_pending_out |-> ctrl_reg.timer <= TIMER_LAST)
        else $error("zero cross wait overran its timeout");

    a_servo_gate: assert property (                                     // R10
        1'b1 |=> dc_servo_enable_out ==
        !($past(pin_s[`SYNC_SERVO_PIN]) || $past(word_now[`SERVO_OFF_POS])))
        else $error("dc servo enable wrong");

    a_cm_follow: assert property (                                      // R11
        1'b1 |=> cm_servo_enable_out == $past(word_now[`CM_SERVO_POS]))
        else $error("common-mode servo does not follow word");

    a_clip_select: assert property (                                    // R17 R18
        1'b1 |=> clip_flag_out == ($past(word_now[`THRESH_SEL_POS]) ?
        $past(pin_s[`SYNC_OVER_LOW]) : $past(pin_s[`SYNC_OVER_HIGH])))
        else $error("clip flag threshold selection wrong");

    a_aux_follow: assert property (                                     // R19
        1'b1 |=> {aux_output_4_out, aux_output_3_out, aux_output_2_out,
        aux_output_1_out} == $past(word_now[`AUX_LSB +: `AUX_BITS]))
        else $error("aux outputs do not follow word");

    // ==========================================================
    // Gain sequencing, decibel mapping and servo pin checks
    a_zc_cross: assert property (                                       // R14
        zc_pending_out && crossing && !force_unity |=>
        gain_code_out == $past(target_code) && !zc_pending_out)
        else $error("crossing did not apply pending gain");

    a_zc_timeout: assert property (                                     // R15
        zc_pending_out && timer_done && !force_unity |=>
        gain_code_out == $past(target_code) && !zc_pending_out)
        else $error("timeout did not apply pending gain");

    a_zc_off_idle: assert property (                                    // R16
        !zc_enabled |=> !zc_pending_out)
        else $error("gain change waited with zero cross off");

    a_wait_entry: assert property (                                     // R14
        $rose(zc_pending_out) |-> $past(zc_enabled) && !$past(force_unity))
        else $error("wait entered without zero cross enable");

    a_timer_clear: assert property (                                    // R15
        !zc_pending_out |-> ctrl_reg.timer == '0)
        else $error("timeout counter not cleared outside wait");

    a_db_step: assert property (                                        // R9
        gain_code_out != `GAIN_UNITY_CODE && gain_code_out <= `GAIN_MAX_CODE |->
        gain_db_out == `GAIN_DB_BITS'({1'b0, gain_code_out} + `GAIN_DB_OFFSET))
        else $error("gain code to decibel step wrong");

    a_db_clamp: assert property (                                       // R9
        gain_code_out > `GAIN_MAX_CODE |-> gain_db_out == `GAIN_MAX_DB)
        else $error("gain above top step not clamped");

    a_unity_db: assert property (                                       // R9 R12
        unity_gain_active_out |-> gain_db_out == `GAIN_UNITY_DB)
        else $error("unity flag without unity gain");

    a_servo_pin: assert property (                                      // R10
        pin_s[`SYNC_SERVO_PIN] |=> !dc_servo_enable_out)
        else $error("servo pin did not disable dc servo");

    c_latch: cover property (cs_rise);

    c_clamp: cover property (gain_code_out > `GAIN_MAX_CODE);

    c_zc_cross: cover property (zc_pending_out && crossing && !force_unity);

    c_zc_timeout: cover property (zc_pending_out && timer_done && !crossing);

    c_force: cover property ($rose(force_unity) ##[1:20] $fell(force_unity));

endmodule : preamp_serial_control_port

// File: core/preamp_unused_placeholder_none.sv
`timescale 1ns/100ps
// Intentionally empty: no further logic.

// File: verif/preamp_host_model.sv
// Host serial master model for the preamp control port.
// Assumes it alone drives chip select, serial clock and serial data.
`timescale 1ns/100ps

module preamp_host_model (
    input  wire logic dev_data_in,
    input  wire logic dev_oe_in,
    output logic      host_clk_out,
    output logic      host_cs_n_out,
    output logic      host_data_out
);
    logic oe_mid;

    initial begin
        host_clk_out  = 1'b0;
        host_cs_n_out = 1'b1;
        host_data_out = 1'b0;
        oe_mid        = 1'b0;
    end

    // ==========================================================
    // Framed transfer, 15 ns clock, idle low between frames
    task automatic xfer(input logic [31:0] bits, input int n, output logic [31:0] got);
        got = '0;
        host_cs_n_out = 1'b0;
        #20 oe_mid = dev_oe_in;
        for (int i = n - 1; i >= 0; i--) begin
            host_data_out = bits[i];
            #5.5 host_clk_out = 1'b1;
            #7.5 host_clk_out = 1'b0;
            #2 got = {got[30:0], dev_data_in};
        end
        #5 host_cs_n_out = 1'b1;
        // Released line shows no stale bit
        host_data_out = ~host_data_out;
    endtask : xfer

    // ==========================================================
    // Deliberate clock and data activity with chip select high
    task automatic idle_wiggle(input int n);
        for (int i = 0; i < n; i++) begin
            host_data_out = ~host_data_out;
            #7.5 host_clk_out = 1'b1;
            #7.5 host_clk_out = 1'b0;
        end
    endtask : idle_wiggle
endmodule : preamp_host_model

// File: verif/preamp_serial_control_port_tb.sv
// Self-checking bench for the preamp serial control port.
// Assumes the host model file is compiled first.
`timescale 1ns/100ps
`include "preamp_params_params.svh"

module preamp_serial_control_port_tb;
    localparam int ZC_CYC = 50;
    logic clk_sys, rst_n, sclk, cs_n, sdata, serial_out, sdo_oe;
    logic servo_pin, force_pin, zc_en, sign, ov_hi, ov_lo;
    logic [`GAIN_BITS-1:0] gain_code;
    logic [`GAIN_DB_BITS-1:0] gain_db;
    logic unity, pend, dc_en, cm_en, clip, a1, a2, a3, a4, primed;
    logic [15:0] last;
    logic [31:0] got;
    int checks, miscompares;
    logic sdo_seen;
    // Released data line reads inverted so a stale bit cannot pass
    assign sdo_seen = sdo_oe ? serial_out : ~serial_out;

    preamp_serial_control_port #(.ZC_TIMEOUT_CYCLES(ZC_CYC)) dut (
        .clk_sys_in(clk_sys), .rst_n_in(rst_n), .serial_clk_in(sclk),
        .cs_n_in(cs_n), .serial_in(sdata), .serial_out_out(serial_out),
        .serial_out_oe_out(sdo_oe), .servo_disable_pin_in(servo_pin),
        .unity_gain_force_in(force_pin), .zero_cross_enable_in(zc_en),
        .input_sign_in(sign), .over_high_in(ov_hi), .over_low_in(ov_lo),
        .gain_code_out(gain_code), .gain_db_out(gain_db),
        .unity_gain_active_out(unity), .zc_pending_out(pend),
        .dc_servo_enable_out(dc_en), .cm_servo_enable_out(cm_en),
        .clip_flag_out(clip), .aux_output_1_out(a1), .aux_output_2_out(a2),
        .aux_output_3_out(a3), .aux_output_4_out(a4));

    preamp_host_model host (.dev_data_in(sdo_seen), .dev_oe_in(sdo_oe),
        .host_clk_out(sclk), .host_cs_n_out(cs_n), .host_data_out(sdata));

    // ==========================================================
    // Helpers
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    task automatic cyc(input int n);
        repeat (n) @(negedge clk_sys);
    endtask : cyc

    task automatic tally_and_finish;
        $display("checks=%0d miscompares=%0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : tally_and_finish

    // Link register is unreset, so read-back is judged from the second frame
    task automatic load(input logic [15:0] w);
        host.xfer({16'h0000, w}, 16, got);
        chk(host.oe_mid, 1'b1);
        if (primed) chk(got[15:1], last[14:0]);
        primed = 1'b1;
        last = w;
        cyc(6);
    endtask : load

    task automatic check_word(input logic [15:0] w);
        logic [5:0] c;
        c = w[5:0];
        chk(gain_db, (c == 6'h00) ? 32'h0 : (c > 6'h38) ? 32'h41 : c + 32'h9);
        if (c <= 6'h38) chk(gain_code, c);
        chk(unity, c == 6'h00);
        chk(dc_en, !(servo_pin | w[7]));
        chk(cm_en, w[8]);
        chk(clip, w[9] ? ov_lo : ov_hi);
        chk({a4, a3, a2, a1}, w[15:12]);
    endtask : check_word

    initial begin
        clk_sys = 1'b0;
        forever #12.5 clk_sys = ~clk_sys;
    end

    initial begin
        #200000 miscompares++;
        tally_and_finish();
    end

    // ==========================================================
    // Main sequence
    initial begin
        logic [15:0] tbl [6];
        tbl = '{16'h1001, 16'h2238, 16'h4180, 16'h833f, 16'h0080, 16'hf214};
        {rst_n, servo_pin, force_pin, zc_en, sign, ov_hi, ov_lo, primed} = '0;
        checks = 0;
        miscompares = 0;
        cyc(8);
        rst_n = 1'b1;
        cyc(2);
        chk({unity, dc_en, cm_en, clip, pend, a4, a3, a2, a1, gain_code, gain_db}, 32'h300000);
        chk(sdo_oe, 1'b0);
        foreach (tbl[i]) begin
            {servo_pin, ov_lo, ov_hi} = i[2:0];
            load(tbl[i]);
            check_word(tbl[i]);
        end
        force_pin = 1'b1;
        cyc(4);
        chk(gain_code, 6'h00);
        load(16'h001e);
        chk(gain_code, 6'h00);
        force_pin = 1'b0;
        cyc(5);
        check_word(16'h001e);
        host.xfer(32'h00a5, 8, got);
        cyc(6);
        check_word(16'h1ea5);
        host.xfer({16'h0c3a, 16'h2014}, 32, got);
        cyc(6);
        chk(got[31:17], 15'h1ea5);
        chk(got[16:1], 16'h0c3a);
        check_word(16'h2014);
        last = 16'h2014;
        host.idle_wiggle(20);
        cyc(6);
        check_word(16'h2014);
        chk(sdo_oe, 1'b0);
        zc_en = 1'b1;
        cyc(4);
        load(16'h0005);
        chk({pend, gain_code}, {1'b1, 6'h14});
        sign = ~sign;
        cyc(6);
        chk({pend, gain_code}, {1'b0, 6'h05});
        load(16'h0007);
        cyc(30);
        chk({pend, gain_code}, {1'b1, 6'h05});
        cyc(30);
        chk({pend, gain_code}, {1'b0, 6'h07});
        tally_and_finish();
    end
endmodule : preamp_serial_control_port_tb
